// file: dosl_sel.sv
`timescale 1ns/100ps
`default_nettype none
package dosl_pkg;
  // group layout: eight outputs per group, two groups
  localparam int GRP_W = 8;
  localparam int OUT_W = 16;
  // byte selectors on the expander bus
  localparam logic [2:0] BY_OUT_A  = 3'h0;
  localparam logic [2:0] BY_OUT_B  = 3'h1;
  localparam logic [2:0] BY_DEF_A  = 3'h2;
  localparam logic [2:0] BY_DEF_B  = 3'h3;
  localparam logic [2:0] BY_HOLD   = 3'h4;
  localparam logic [2:0] BY_FLAG   = 3'h5;
  localparam logic [2:0] BY_STAT_A = 3'h0;
  localparam logic [2:0] BY_STAT_B = 3'h1;
  localparam logic [2:0] BY_STAT_C = 3'h2;
  // reset values
  localparam logic [15:0] OUT_RST = 16'h0000;
  localparam logic [15:0] DEF_RST = 16'h0000;
  localparam logic [7:0]  RD_NONE = 8'h00;
  // module identification, value arbitrary
  localparam logic [3:0] MOD_ID = 4'h5;
  // bus silence that counts as a control module failure
  localparam int TMO_US  = 10;
  localparam int CLK_MHZ = 100;
  localparam logic [15:0] TMO_CYC = 16'(TMO_US * CLK_MHZ);
  localparam logic [15:0] TMR_ONE = 16'h0001;
  // selector state
  typedef struct packed {
    logic [15:0] q;
  } dosl_sel_st_t;
endpackage

module dosl_sel (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        tmo,
  input  wire logic        hold,
  input  wire logic [15:0] out_d,
  input  wire logic [15:0] def_d,
  output logic      [15:0] sel_q
);
  dosl_pkg::dosl_sel_st_t st_reg;   // registered selection
  dosl_pkg::dosl_sel_st_t st_next;  // next selection

  // pick output data, or default data on a time-out without hold
  always_comb begin
    st_next = st_reg;
    if (tmo && !hold) begin
      st_next.q = def_d;
    end else begin
      st_next.q = out_d;
    end
  end

  // registered so the switch drivers never see a glitch; off under reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg.q <= dosl_pkg::OUT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sel_q = st_reg.q;
endmodule
`default_nettype wire

// file: dosl_top.sv
`timescale 1ns/100ps
`default_nettype none
module dosl_top (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [5:0]  ADDRESS_SWITCH,
  input  wire logic        BUS_SEL,
  input  wire logic [5:0]  BUS_ADDR,
  input  wire logic        BUS_WR,
  input  wire logic        BUS_RD,
  input  wire logic [2:0]  BUS_BYTE,
  input  wire logic [7:0]  BUS_WDATA,
  output logic      [7:0]  BUS_RDATA,
  output logic             BUS_RVALID,
  output logic      [7:0]  OUT_A,
  output logic      [7:0]  OUT_B,
  output logic      [7:0]  LED_A,
  output logic      [7:0]  LED_B,
  output logic             TIMEOUT
);
  // state of the block, apart from the selector register in u_sel
  typedef struct packed {
    logic [5:0]  addr_s1;   // switch sync, first stage
    logic [5:0]  addr_s2;   // switch sync, second stage
    logic [15:0] out_r;     // output register, A low byte
    logic [15:0] def_r;     // default register
    logic        hold;      // hold-or-default latch
    logic        flag;      // module status flag
    logic        tmo;       // time-out present
    logic [15:0] tmr;       // cycles since last access at our address, held at TMO_LAST once timed out
    logic [7:0]  rdata;     // read data
    logic        rvalid;    // read answer strobe
  } dosl_st_t;

  dosl_st_t    st_reg;   // current state
  dosl_st_t    st_next;  // next state
  logic [15:0] sel_q;    // selected output states
  logic        hit;      // access at our address

  // time-out edge: counter value one below the full count
  localparam logic [15:0] TMO_LAST = dosl_pkg::TMO_CYC - dosl_pkg::TMR_ONE;
  // unused middle bits of the id/status byte read as zero
  localparam logic [2:0]  STAT_GAP = 3'h0;

  // only the second sync stage feeds the compare
  assign hit = BUS_SEL && (BUS_ADDR == st_reg.addr_s2);

  // bus writes, reads and the bus fault timer
  always_comb begin
    st_next         = st_reg;
    st_next.addr_s1 = ADDRESS_SWITCH;
    st_next.addr_s2 = st_reg.addr_s1;
    st_next.rvalid  = 1'b0;
    if (hit) begin
      // an access at our address proves the controller alive
      st_next.tmr = '0;
      st_next.tmo = 1'b0;
    end else if (st_reg.tmr >= TMO_LAST) begin
      // time-out is sticky until the controller comes back
      st_next.tmo  = 1'b1;
      st_next.flag = 1'b0;
    end else begin
      st_next.tmr = st_reg.tmr + dosl_pkg::TMR_ONE;
    end
    // writes land in the byte picked by the selector
    if (hit && BUS_WR) begin
      case (BUS_BYTE)
        dosl_pkg::BY_OUT_A: st_next.out_r[7:0]  = BUS_WDATA;
        dosl_pkg::BY_OUT_B: st_next.out_r[15:8] = BUS_WDATA;
        dosl_pkg::BY_DEF_A: st_next.def_r[7:0]  = BUS_WDATA;
        dosl_pkg::BY_DEF_B: st_next.def_r[15:8] = BUS_WDATA;
        dosl_pkg::BY_HOLD:  st_next.hold = BUS_WDATA[0];
        dosl_pkg::BY_FLAG:  st_next.flag = BUS_WDATA[0];
        default: ;  // unused byte selectors are ignored
      endcase
    end
    // reads answer one edge later with a one-cycle strobe
    if (hit && BUS_RD && !BUS_WR) begin
      st_next.rvalid = 1'b1;
      case (BUS_BYTE)
        dosl_pkg::BY_STAT_A: st_next.rdata = sel_q[7:0];
        dosl_pkg::BY_STAT_B: st_next.rdata = sel_q[15:8];
        dosl_pkg::BY_STAT_C:
          st_next.rdata = {dosl_pkg::MOD_ID, STAT_GAP, st_reg.flag};
        default:             st_next.rdata = dosl_pkg::RD_NONE;
      endcase
    end
  end

  // all registers clear at reset; defaults zero so a time-out turns all off
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_reg         <= '0;
      st_reg.out_r   <= dosl_pkg::OUT_RST;
      st_reg.def_r   <= dosl_pkg::DEF_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // one selector serves both groups
  dosl_sel u_sel (
    .clk     (CLK),
    .reset_n (RESET_N),
    .tmo     (st_reg.tmo),
    .hold    (st_reg.hold),
    .out_d   (st_reg.out_r),
    .def_d   (st_reg.def_r),
    .sel_q   (sel_q)
  );

  // outputs and indicators share one selected value
  assign OUT_A      = sel_q[7:0];
  assign OUT_B      = sel_q[15:8];
  assign LED_A      = sel_q[7:0];
  assign LED_B      = sel_q[15:8];
  assign BUS_RDATA  = st_reg.rdata;
  assign BUS_RVALID = st_reg.rvalid;
  assign TIMEOUT    = st_reg.tmo;

  // all checks run on the block clock and rest while reset is held
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // no time-out: next selection is the output register
  property p_norm;
    !st_reg.tmo |=> sel_q == $past(st_reg.out_r);
  endproperty
  a_norm: assert property (p_norm) else $error("normal select wrong");

  // time-out without hold: next selection is the default register
  property p_dflt;
    st_reg.tmo && !st_reg.hold |=> sel_q == $past(st_reg.def_r);
  endproperty
  a_dflt: assert property (p_dflt) else $error("default select wrong");

  // time-out with hold: the pins keep the output register
  property p_hold;
    st_reg.tmo && st_reg.hold |=> {OUT_B, OUT_A} == $past(st_reg.out_r);
  endproperty
  a_hold: assert property (p_hold) else $error("hold select wrong");

  // first edge after reset sees cleared registers and flag
  property p_rst;
    $past(!RESET_N) |-> st_reg.def_r == '0 && st_reg.out_r == '0 && !st_reg.flag;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");

  // indicators mirror the switch drive
  property p_led;
    LED_A == OUT_A && LED_B == OUT_B;
  endproperty
  a_led: assert property (p_led) else $error("indicator mismatch");

  // a group B write reaches the register, then the pins
  property p_wr;
    hit && BUS_WR && BUS_BYTE == dosl_pkg::BY_OUT_B
      |=> st_reg.out_r[15:8] == $past(BUS_WDATA) ##1 OUT_B == $past(st_reg.out_r[15:8]);
  endproperty
  a_wr: assert property (p_wr) else $error("output write lost");

  // an access at another address gives no read answer and leaves the output register unchanged
  property p_miss;
    BUS_SEL && BUS_ADDR != st_reg.addr_s2 |=> !BUS_RVALID && $stable(st_reg.out_r);
  endproperty
  a_miss: assert property (p_miss) else $error("answered foreign address");

  // the last silent cycle raises the time-out and drops the flag
  property p_tmo;
    !st_reg.tmo && !hit && st_reg.tmr == TMO_LAST |=> TIMEOUT && !st_reg.flag;
  endproperty
  a_tmo: assert property (p_tmo) else $error("time-out not raised");

  // id/status byte layout
  property p_stat;
    hit && BUS_RD && !BUS_WR && BUS_BYTE == dosl_pkg::BY_STAT_C
      |=> BUS_RVALID && BUS_RDATA == {dosl_pkg::MOD_ID, STAT_GAP, $past(st_reg.flag)};
  endproperty
  a_stat: assert property (p_stat) else $error("status byte wrong");

  // group A readback shows the driven states
  property p_rdb;
    hit && BUS_RD && !BUS_WR && BUS_BYTE == dosl_pkg::BY_STAT_A |=> BUS_RDATA == $past(OUT_A);
  endproperty
  a_rdb: assert property (p_rdb) else $error("readback wrong");

  // a flag write lands in the flag one edge later
  property p_flg;
    hit && BUS_WR && BUS_BYTE == dosl_pkg::BY_FLAG
      |=> st_reg.flag == $past(BUS_WDATA[0]);
  endproperty
  a_flg: assert property (p_flg) else $error("flag write lost");

  // the hold latch takes bit zero of its byte
  property p_hlat;
    hit && BUS_WR && BUS_BYTE == dosl_pkg::BY_HOLD
      |=> st_reg.hold == $past(BUS_WDATA[0]);
  endproperty
  a_hlat: assert property (p_hlat) else $error("hold latch write lost");

  // any access at our address ends a time-out on the next edge
  property p_back;
    hit |=> !TIMEOUT;
  endproperty
  a_back: assert property (p_back) else $error("time-out outlived an access");

  // main scenarios: defaults, hold, read then write, foreign access
  c_tmo:  cover property (st_reg.tmo && !st_reg.hold && st_reg.def_r != '0);
  c_hold: cover property (st_reg.tmo && st_reg.hold);
  c_read: cover property (BUS_RVALID ##1 hit && BUS_WR);
  c_miss: cover property (BUS_SEL && BUS_ADDR != st_reg.addr_s2);
endmodule
`default_nettype wire

// file: dosl_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
// control module end of the expander bus
module dosl_ctl_model (
  input  wire logic       clk,
  output logic            sel,
  output logic      [5:0] addr,
  output logic            wr,
  output logic            rd,
  output logic      [2:0] bsel,
  output logic      [7:0] wdata
);
  // bus idle before the first access
  initial begin
    sel = 1'b0;
    addr = 6'h00;
    wr = 1'b0;
    rd = 1'b0;
    bsel = 3'h0;
    wdata = 8'h00;
  end
  // one strobe cycle per access; released address, byte and data lines show inverted junk, strobes drop to zero
  task automatic acc(input logic w, input logic [2:0] b, input logic [7:0] d,
                     input logic [5:0] a);
    @(posedge clk);
    sel <= 1'b1;
    addr <= a;
    wr <= w;
    rd <= !w;
    bsel <= b;
    wdata <= d;
    @(posedge clk);
    sel <= 1'b0;
    addr <= ~a;
    wr <= 1'b0;
    rd <= 1'b0;
    bsel <= ~b;
    wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [5:0] ADDR = 6'h2a; // our switch setting
  logic       clk;
  logic       reset_n;
  logic       sel, wr, rd;
  logic [5:0] addr;
  logic [2:0] bsel;
  logic [7:0] wdata, rdata, out_a, out_b, led_a, led_b;
  logic       rvalid, tmo;
  logic [7:0] ra, rb, da, db;
  logic [7:0] exp_q[$]; // read answers still owed
  int         miscompares = 0;
  int         n_checks = 0;
  integer     seed = 32'hb7cb6a97;
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dosl_top dut_u (.CLK(clk), .RESET_N(reset_n), .ADDRESS_SWITCH(ADDR), .BUS_SEL(sel),
    .BUS_ADDR(addr), .BUS_WR(wr), .BUS_RD(rd), .BUS_BYTE(bsel), .BUS_WDATA(wdata),
    .BUS_RDATA(rdata), .BUS_RVALID(rvalid), .OUT_A(out_a), .OUT_B(out_b),
    .LED_A(led_a), .LED_B(led_b), .TIMEOUT(tmo));
  dosl_ctl_model ctl_u (.clk(clk), .sel(sel), .addr(addr), .wr(wr), .rd(rd),
    .bsel(bsel), .wdata(wdata));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
    n_checks++;
    if (seen !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wb(input logic [2:0] b, input logic [7:0] d, input logic [5:0] a = ADDR);
    ctl_u.acc(1'b1, b, d, a);
  endtask
  // note the answer first, then issue the read
  task automatic rb_(input logic [2:0] b, input logic [7:0] e);
    exp_q.push_back(e);
    ctl_u.acc(1'b0, b, 8'h00, ADDR);
  endtask
  task automatic outs(input logic [7:0] a, input logic [7:0] b);
    chk("out_a", out_a, a);
    chk("out_b", out_b, b);
    chk("led_a", led_a, a);
    chk("led_b", led_b, b);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // answer watcher: each read pulse pops the oldest note
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious_rvalid", 8'h01, 8'h00);
      else chk("rdata", rdata, exp_q.pop_front());
    end
  end
  // watchdog sized well above the sequence length
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    step(3);
    outs(8'h00, 8'h00);
    rb_(3'h2, {dosl_pkg::MOD_ID, 4'h0});
    rb_(3'h0, 8'h00);
    rb_(3'h7, 8'h00);
    ra = 8'($random(seed));
    rb = 8'($random(seed));
    wb(3'h0, ra);
    wb(3'h1, rb);
    step(2);
    outs(ra, rb);
    rb_(3'h0, ra);
    rb_(3'h1, rb);
    wb(3'h5, 8'h01);
    rb_(3'h2, {dosl_pkg::MOD_ID, 4'h1});
    wb(3'h0, ~ra, 6'h15);
    step(2);
    chk("foreign_addr", out_a, ra);
    // time-out rises exactly the full count after the flag read
    step(int'(dosl_pkg::TMO_CYC) - 5);
    chk("tmo_early", {7'h00, tmo}, 8'h00);
    step(1);
    chk("tmo", {7'h00, tmo}, 8'h01);
    step(1);
    outs(8'h00, 8'h00);
    rb_(3'h2, {dosl_pkg::MOD_ID, 4'h0});
    da = 8'($random(seed));
    db = 8'($random(seed));
    wb(3'h2, da);
    wb(3'h3, db);
    wb(3'h4, 8'h00);
    step(1010);
    outs(da, db);
    // fresh output data so hold and default cannot look alike
    ra = 8'($random(seed));
    rb = 8'($random(seed));
    wb(3'h4, 8'h01);
    wb(3'h0, ra);
    wb(3'h1, rb);
    step(1010);
    chk("tmo_hold", {7'h00, tmo}, 8'h01);
    outs(ra, rb);
    rb_(3'h1, rb);
    wb(3'h5, 8'h01);
    wb(3'h5, 8'h00);
    rb_(3'h2, {dosl_pkg::MOD_ID, 4'h0});
    wb(3'h5, 8'h01);
    // second reset mid-run, with outputs on and the flag set
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    step(3);
    outs(8'h00, 8'h00);
    rb_(3'h2, {dosl_pkg::MOD_ID, 4'h0});
    step(4);
    chk("pending", 8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
